// File: design/ors_pkg.sv
// Purpose: constants for the output range scaling register and its datapath
// Assumes: one 32-bit scaling register on the device register port
// Notes:   widths of the internal results and output registers are plain defaults
package ors_pkg;
  localparam int unsigned ADDR_W       = 16;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned BE_W         = DATA_W / 8;
  localparam int unsigned FIELD_W      = 8;
  localparam int unsigned RESULT_W     = 48;
  localparam int unsigned OUT_W        = 32;
  localparam int unsigned CHAN_N       = 4;

  localparam logic [ADDR_W-1:0] SCALE_OFFSET = 16'h0048;

  localparam int unsigned VOLTAGE_LSB  = 0;
  localparam int unsigned CURRENT_LSB  = 8;
  localparam int unsigned POWER_LSB    = 16;
  localparam int unsigned UNUSED_LSB   = 24;

  localparam int unsigned VOLTAGE_BYTE = 0;
  localparam int unsigned CURRENT_BYTE = 1;
  localparam int unsigned POWER_BYTE   = 2;

  localparam logic [FIELD_W-1:0] FIELD_RESET  = 8'h00;
  localparam logic [DATA_W-1:0]  DATA_ZERO    = 32'h0000_0000;
  localparam logic [FIELD_W-1:0] UNUSED_VALUE = 8'h00;

  // overflow flag bit per output channel
  localparam int unsigned CH_CURRENT   = 0;
  localparam int unsigned CH_VOLTAGE   = 1;
  localparam int unsigned CH_ACTIVE    = 2;
  localparam int unsigned CH_REACTIVE  = 3;

  typedef struct packed {
    logic [FIELD_W-1:0] power;
    logic [FIELD_W-1:0] current;
    logic [FIELD_W-1:0] voltage;
  } ors_scale_t;
endpackage : ors_pkg

// File: design/ors_range_scaler.sv
// Purpose: output range scaling register and the scaled output registers
// Assumes: register port and result strobes are on core_clk_i
//          a count of the result width or more gives a zero output
// Notes:   shifted results wider than the output register are cut; overflow_o flags it
//          the top byte holds no storage, so it always reads back as zero
//          outputs and overflow marks hold until the next result strobe
`timescale 1ns/1ns
`default_nettype none
// Function
// - 32-bit read/write scaling register of byte shift counts, zero after reset.
// - top byte unimplemented: writes ignored, reads return zero.
// - bits 23:16 power shift, shared by active and reactive outputs.
// - bits 15:8 shift count applied to the RMS current result.
// - bits 7:0 shift count applied to the RMS voltage result.
// - each count is a logical right shift, division by two to that power.
module ors_range_scaler (
  input  wire logic                          core_clk_i,
  input  wire logic                          rst_i,
  input  wire logic [ors_pkg::ADDR_W-1:0]    reg_addr_i,
  input  wire logic                          reg_wr_i,
  input  wire logic [ors_pkg::BE_W-1:0]      reg_be_i,
  input  wire logic [ors_pkg::DATA_W-1:0]    reg_wdata_i,
  input  wire logic                          reg_rd_i,
  output logic      [ors_pkg::DATA_W-1:0]    reg_rdata_o,
  output logic                               reg_rvalid_o,
  output logic                               reg_hit_o,
  input  wire logic                          result_valid_i,
  input  wire logic [ors_pkg::RESULT_W-1:0]  current_rms_i,
  input  wire logic [ors_pkg::RESULT_W-1:0]  voltage_rms_i,
  input  wire logic [ors_pkg::RESULT_W-1:0]  active_pwr_i,
  input  wire logic [ors_pkg::RESULT_W-1:0]  reactive_pwr_i,
  output logic      [ors_pkg::OUT_W-1:0]     current_out_o,
  output logic      [ors_pkg::OUT_W-1:0]     voltage_out_o,
  output logic      [ors_pkg::OUT_W-1:0]     active_out_o,
  output logic      [ors_pkg::OUT_W-1:0]     reactive_out_o,
  output logic                               out_valid_o,
  output logic      [ors_pkg::CHAN_N-1:0]    overflow_o
);
  import ors_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    ors_scale_t         scale;
    logic [DATA_W-1:0]  rdata;
    logic               rvalid;
    logic [OUT_W-1:0]   current_out;
    logic [OUT_W-1:0]   voltage_out;
    logic [OUT_W-1:0]   active_out;
    logic [OUT_W-1:0]   reactive_out;
    logic               out_valid;
    logic [CHAN_N-1:0]  overflow;
  } ors_state_t;

  localparam ors_state_t STATE_RESET = '{
    scale:        '{
      power:   FIELD_RESET,
      current: FIELD_RESET,
      voltage: FIELD_RESET
    },
    rdata:        DATA_ZERO,
    rvalid:       1'b0,
    current_out:  DATA_ZERO,
    voltage_out:  DATA_ZERO,
    active_out:   DATA_ZERO,
    reactive_out: DATA_ZERO,
    out_valid:    1'b0,
    overflow:     '0
  };

  ors_state_t state;
  ors_state_t next_state;

  logic               addr_hit;
  logic               wr_hit;
  logic               wr_power;
  logic               wr_current;
  logic               wr_voltage;
  logic [DATA_W-1:0]  scale_word;
  logic [DATA_W-1:0]  read_word;
  logic [FIELD_W-1:0] cnt_power;
  logic [FIELD_W-1:0] cnt_current;
  logic [FIELD_W-1:0] cnt_voltage;
  logic [OUT_W-1:0]   sh_current;
  logic [OUT_W-1:0]   sh_voltage;
  logic [OUT_W-1:0]   sh_active;
  logic [OUT_W-1:0]   sh_reactive;
  logic [CHAN_N-1:0]  sh_overflow;

  ////////////////////////////////////////////////////////////////////////////
  // shifters

  ors_shifter #(
    .IN_W  (RESULT_W),
    .CNT_W (FIELD_W),
    .OUT_W (OUT_W)
  ) u_sh_current (
    .value_i    (current_rms_i),
    .count_i    (cnt_current),
    .result_o   (sh_current),
    .overflow_o (sh_overflow[CH_CURRENT])
  );

  ors_shifter #(
    .IN_W  (RESULT_W),
    .CNT_W (FIELD_W),
    .OUT_W (OUT_W)
  ) u_sh_voltage (
    .value_i    (voltage_rms_i),
    .count_i    (cnt_voltage),
    .result_o   (sh_voltage),
    .overflow_o (sh_overflow[CH_VOLTAGE])
  );

  ors_shifter #(
    .IN_W  (RESULT_W),
    .CNT_W (FIELD_W),
    .OUT_W (OUT_W)
  ) u_sh_active (
    .value_i    (active_pwr_i),
    .count_i    (cnt_power),
    .result_o   (sh_active),
    .overflow_o (sh_overflow[CH_ACTIVE])
  );

  ors_shifter #(
    .IN_W  (RESULT_W),
    .CNT_W (FIELD_W),
    .OUT_W (OUT_W)
  ) u_sh_reactive (
    .value_i    (reactive_pwr_i),
    .count_i    (cnt_power),
    .result_o   (sh_reactive),
    .overflow_o (sh_overflow[CH_REACTIVE])
  );

  ////////////////////////////////////////////////////////////////////////////
  // address decode and read word

  always_comb begin
    addr_hit    = (reg_addr_i == SCALE_OFFSET);
    wr_hit      = reg_wr_i && addr_hit;
    wr_power    = wr_hit && reg_be_i[POWER_BYTE];
    wr_current  = wr_hit && reg_be_i[CURRENT_BYTE];
    wr_voltage  = wr_hit && reg_be_i[VOLTAGE_BYTE];

    cnt_power   = state.scale.power;
    cnt_current = state.scale.current;
    cnt_voltage = state.scale.voltage;

    scale_word  = {UNUSED_VALUE, cnt_power,
                   cnt_current, cnt_voltage};
    read_word   = addr_hit ? scale_word : DATA_ZERO;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_state = state;

    // register write, byte lanes of the three counts only
    if (wr_power) begin
      next_state.scale.power = reg_wdata_i[POWER_LSB +: FIELD_W];
    end
    if (wr_current) begin
      next_state.scale.current = reg_wdata_i[CURRENT_LSB +: FIELD_W];
    end
    if (wr_voltage) begin
      next_state.scale.voltage = reg_wdata_i[VOLTAGE_LSB +: FIELD_W];
    end

    // register read, unmapped address reads zero
    // a read in the cycle of a write returns the old counts
    next_state.rvalid = reg_rd_i;
    if (reg_rd_i) begin
      next_state.rdata = read_word;
    end

    // scaled outputs captured on each new result set
    next_state.out_valid = result_valid_i;
    if (result_valid_i) begin
      next_state.current_out  = sh_current;
      next_state.voltage_out  = sh_voltage;
      next_state.active_out   = sh_active;
      next_state.reactive_out = sh_reactive;
      next_state.overflow     = sh_overflow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  always_comb begin
    // register port
    reg_rdata_o    = state.rdata;
    reg_rvalid_o   = state.rvalid;
    reg_hit_o      = addr_hit;

    // scaled results
    current_out_o  = state.current_out;
    voltage_out_o  = state.voltage_out;
    active_out_o   = state.active_out;
    reactive_out_o = state.reactive_out;
    out_valid_o    = state.out_valid;
    overflow_o     = state.overflow;
  end
endmodule // ors_range_scaler
`default_nettype wire

// File: design/ors_shifter.sv
// Purpose: logical right shift of one internal result, cut to output width
// Assumes: count may exceed the input width, the result is then zero
// Notes:   overflow marks set bits lost above the output width
`timescale 1ns/1ns
`default_nettype none
module ors_shifter #(
  parameter int unsigned IN_W  = 48,
  parameter int unsigned CNT_W = 8,
  parameter int unsigned OUT_W = 32
) (
  input  wire logic [IN_W-1:0]  value_i,
  input  wire logic [CNT_W-1:0] count_i,
  output logic      [OUT_W-1:0] result_o,
  output logic                  overflow_o
);
  logic [IN_W-1:0] shifted;

  always_comb begin
    shifted    = value_i >> count_i;
    result_o   = shifted[OUT_W-1:0];
    overflow_o = |shifted[IN_W-1:OUT_W];
  end
endmodule // ors_shifter
`default_nettype wire

// File: sim/ors_range_scaler_bench.sv
// Purpose: self-checking bench for the range scaler
// Assumes: strobe register port, one clock
// Notes:   drivers queue expected results in order
`timescale 1ns/1ns
`default_nettype none
module ors_range_scaler_bench;
  import ors_pkg::*;
  logic core_clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, result_valid_i = 0;
  logic reg_rvalid_o, reg_hit_o, out_valid_o;
  logic [3:0] reg_be_i = 0, overflow_o;
  logic [15:0] reg_addr_i = 0;
  logic [23:0] sc = 0;
  logic [31:0] reg_wdata_i = 0, reg_rdata_o, current_out_o, voltage_out_o, active_out_o;
  logic [31:0] reactive_out_o;
  logic [47:0] current_rms_i = 0, voltage_rms_i = 0, active_pwr_i = 0, reactive_pwr_i = 0;
  logic [31:0] rq[$];
  logic [131:0] oq[$];
  int fails = 0, check_count = 0;
  ors_range_scaler dut (.core_clk_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_be_i, .reg_wdata_i,
    .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .reg_hit_o, .result_valid_i, .current_rms_i,
    .voltage_rms_i, .active_pwr_i, .reactive_pwr_i, .current_out_o, .voltage_out_o,
    .active_out_o, .reactive_out_o, .out_valid_o, .overflow_o);
  always #25 core_clk_i = ~core_clk_i;
  task automatic cmp_read(input logic [31:0] got);
    check_count++;
    if (rq.size() == 0 || got !== rq.pop_front()) begin
      fails++;
      $display("Error at %0t: read data differs from expected", $time);
    end
  endtask
  task automatic cmp_out(input logic [131:0] got);
    check_count++;
    if (oq.size() == 0 || got !== oq.pop_front()) begin
      fails++;
      $display("Error at %0t: scaled outputs differ from expected", $time);
    end
  endtask
  task automatic cmp_hit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: address hit differs from expected", $time);
    end
  endtask
  function automatic logic [32:0] scl(input logic [47:0] x, input logic [7:0] c);
    logic [47:0] s;
    s = x >> c;
    return {|s[47:32], s[31:0]};
  endfunction
  always @(negedge core_clk_i) begin
    if (reg_rvalid_o === 1'b1) cmp_read(reg_rdata_o);
    if (out_valid_o === 1'b1) cmp_out({current_out_o, voltage_out_o, active_out_o,
      reactive_out_o, overflow_o});
  end
  task automatic go(input logic w, r, v);
    {reg_wr_i, reg_rd_i, result_valid_i} = {w, r, v};
    @(posedge core_clk_i) #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [3:0] b, input logic [31:0] d);
    {reg_addr_i, reg_be_i, reg_wdata_i} = {a, b, d};
    go(1, 0, 0);
    for (int i = 0; i < 3; i++)
      if (a == SCALE_OFFSET && b[i]) sc[i*8 +: 8] = reg_wdata_i[i*8 +: 8];
  endtask
  task automatic rd(input logic [15:0] a);
    reg_addr_i = a;
    rq.push_back(a == SCALE_OFFSET ? {8'h00, sc} : 32'h0);
    go(0, 1, 0);
    cmp_hit(reg_hit_o, a == SCALE_OFFSET);
  endtask
  task automatic res();
    logic [32:0] c, v, p, r;
    {current_rms_i, voltage_rms_i, active_pwr_i} = 144'({$urandom, $urandom, $urandom, $urandom, $urandom});
    reactive_pwr_i = $urandom % 2 ? active_pwr_i : {$urandom, 16'h0};
    c = scl(current_rms_i, sc[15:8]);
    v = scl(voltage_rms_i, sc[7:0]);
    p = scl(active_pwr_i, sc[23:16]);
    r = scl(reactive_pwr_i, sc[23:16]);
    oq.push_back({c[31:0], v[31:0], p[31:0], r[31:0], r[32], p[32], v[32], c[32]});
    go(0, 0, 1);
  endtask
  initial begin
    void'($urandom(44963));
    repeat (8) @(posedge core_clk_i);
    #1 rst_i = 0;
    rd(SCALE_OFFSET);
    for (int b = 0; b < 16; b++) begin
      wr(SCALE_OFFSET, 4'(b), $urandom);
      rd(SCALE_OFFSET);
    end
    wr(16'h004c, 4'hf, $urandom);
    rd(16'h004c);
    rd(SCALE_OFFSET);
    $display("register tests done");
    for (int n = 0; n < 40; n++) begin
      if (n % 8 == 0 && n < 24) wr(SCALE_OFFSET, 4'hf, $urandom & 32'hff3f3f3f);
      if (n % 8 == 0 && n >= 24)
        wr(SCALE_OFFSET, 4'hf, $urandom & 32'hff0f0f0f | 32'h0010_1010);
      res();
    end
    go(0, 0, 0);
    go(0, 0, 0);
    $display("scaling tests done");
    wrap_up();
  end
  initial begin
    #200000 fails++;
    wrap_up();
  end
  task automatic wrap_up();
    if (rq.size() != 0 || oq.size() != 0) fails++;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
endmodule // ors_range_scaler_bench
bind ors_range_scaler ors_range_scaler_checker chk (.core_clk_i, .rst_i, .reg_addr_i,
  .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .result_valid_i, .active_pwr_i, .reactive_pwr_i,
  .active_out_o, .reactive_out_o, .out_valid_o);
`default_nettype wire

// File: sim/ors_range_scaler_checker.sv
// Purpose: port checker for the range scaler
// Assumes: one clock, rst_i synchronous active high
// Notes:   watches read port and power outputs
`timescale 1ns/1ns
`default_nettype none
module ors_range_scaler_checker import ors_pkg::*; (
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        reg_rvalid_o,
  input wire logic        result_valid_i,
  input wire logic [47:0] active_pwr_i,
  input wire logic [47:0] reactive_pwr_i,
  input wire logic [31:0] active_out_o,
  input wire logic [31:0] reactive_out_o,
  input wire logic        out_valid_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_read_latency: assert property (reg_rvalid_o == $past(reg_rd_i))
    else $error("read valid not one cycle after read");
  a_top_byte_zero: assert property (reg_rvalid_o |-> reg_rdata_o[31:24] == 8'h00)
    else $error("top byte not zero");
  a_miss_reads_zero: assert property (reg_rd_i && reg_addr_i != SCALE_OFFSET |=> reg_rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without read");
  a_power_shared: assert property (result_valid_i && active_pwr_i == reactive_pwr_i |=> active_out_o == reactive_out_o)
    else $error("power outputs scaled differently");
  a_out_latency: assert property (out_valid_o == $past(result_valid_i))
    else $error("output valid not one cycle after result");
endmodule // ors_range_scaler_checker
`default_nettype wire
